// file: src/ebh_map.svh
`ifndef EBH_MAP_SVH
`define EBH_MAP_SVH
// Clock divider: ref clock to double-rate select phase
`define EBH_CLK_DIV 4
// Internal IO ports for the clock chip
`define EBH_CLOCK_ADDR_PORT 16'h0070
`define EBH_CLOCK_DATA_PORT 16'h0071
// Top of the one megabyte window
`define EBH_ONE_MEG 24'h10_0000
// Pseudo-hidden refresh holds the host bus this many host clocks
`define EBH_REFRESH_HOLD 2
// Extended 8-bit cycle length for internal register access, in cycles
`define EBH_EXT_CYCLES 6
`endif

// file: src/ebh_pkg.sv
package ebh_pkg;
  // Bus owner for the current cycle
  typedef enum logic [1:0] {EBH_OWN_HOST, EBH_OWN_DMA, EBH_OWN_MASTER, EBH_OWN_REFRESH} ebh_owner_t;
  // Host side request to start an ISA cycle
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_write;
    logic is_refresh;
    logic is_dma;
    logic is_rom;
    logic high_byte;
    logic [23:0] addr;
  } ebh_req_t;
  // Command strobes, active low on the bus
  typedef struct packed {
    logic memr_n;
    logic memw_n;
    logic smemr_n;
    logic smemw_n;
    logic ior_n;
    logic iow_n;
    logic bhe_n;
  } ebh_cmd_t;
endpackage : ebh_pkg

// file: src/ebh_mux_phase.sv
`timescale 1ns/10ps
`include "ebh_map.svh"
// ********************************************
// Bus clock and double-rate select generator
// ********************************************
module ebh_mux_phase #(
  parameter int DIV = `EBH_CLK_DIV
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  output logic bus_clock_out,
  output logic bus_clock_double_out,
  output logic phase_tick_out
);
  logic [7:0] div_count;
  logic [1:0] phase;
  wire div_end = (div_count == 8'(DIV - 1));

  // Divider yields one tick per quarter of the bus clock
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      div_count <= 8'h00;
      phase <= 2'h0;
      phase_tick_out <= 1'b0;
    end else begin
      div_count <= div_end ? 8'h00 : div_count + 8'h01;
      phase_tick_out <= div_end;
      if (div_end) begin
        phase <= phase + 2'h1;
      end
    end
  end

  // Outputs straight from flops, double rate toggles each quarter
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bus_clock_out <= 1'b0;
      bus_clock_double_out <= 1'b0;
    end else if (div_end) begin
      bus_clock_double_out <= ~phase[0];
      bus_clock_out <= (phase + 2'h1) >= 2'h2;
    end
  end
endmodule : ebh_mux_phase

// file: src/ebh_isa_host.sv
`timescale 1ns/10ps
`include "ebh_map.svh"
module ebh_isa_host #(
  parameter int CYCLE_LEN = `EBH_EXT_CYCLES,
  parameter int HOLD_LEN = `EBH_REFRESH_HOLD
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire ebh_pkg::ebh_req_t req_in,
  input wire logic dma_last_in,
  input wire logic [2:0] dma_channel_in,
  input wire logic nmi_enable_in,
  input wire logic aux_latch_req_in,
  output logic busy_out,
  output logic host_bus_hold_out,
  output logic master_active_out,
  output logic master_refresh_req_out,
  output logic master_internal_io_out,
  output logic [23:0] master_addr_out,
  output logic mem_cs16_out,
  input wire logic master_n_in,
  input wire logic [23:0] addr_pins_in,
  input wire ebh_pkg::ebh_cmd_t cmd_pins_in,
  input wire logic ready_pin_in,
  input wire logic refresh_n_pin_in,
  input wire logic mem_cs16_n_in,
  input wire logic chan_check_n_in,
  input wire logic [3:0] irq_muxed_in,
  input wire logic [1:0] dma_req_muxed_in,
  output logic [23:17] upper_addr_out,
  output logic upper_addr_oe_out,
  output logic [19:0] low_addr_out,
  output ebh_pkg::ebh_cmd_t cmd_out,
  output logic cmd_oe_out,
  output logic ready_out,
  output logic ready_oe_out,
  output logic refresh_n_out,
  output logic refresh_oe_out,
  output logic ale_out,
  output logic aen_out,
  output logic io_cs16_n_out,
  output logic io_cs16_oe_out,
  output logic nmi_out,
  output logic tc_out,
  output logic [2:0] dma_ack_encoded_out,
  output logic aux_latch_select_n_out,
  output logic clock_chip_addr_strobe_n_out,
  output logic clock_chip_write_strobe_n_out,
  output logic clock_chip_data_strobe_n_out,
  output logic boot_rom_clock_chip_sel_n_out,
  output logic [15:0] irq_request_out,
  output logic [7:0] dma_request_out,
  output logic expansion_bus_clock_out,
  output logic expansion_bus_clock_double_out
);
  import ebh_pkg::*;

  typedef enum logic [1:0] {EBH_IDLE, EBH_ADDR, EBH_CMD, EBH_DONE} ebh_state_t;

  // ********************************************
  // Synchronisers for pins
  // ********************************************
  logic [1:0] master_sync, ready_sync, refresh_sync, check_sync, cs16_sync;
  logic [3:0] irq_meta, irq_sync;
  logic [1:0] dreq_meta, dreq_sync;
  logic [23:0] addr_meta, addr_sync;
  ebh_cmd_t cmd_meta, cmd_sync;

  // Two flops on every outside input before use
  always_ff @(posedge ref_clk_in) begin
    master_sync <= {master_sync[0], master_n_in};
    ready_sync <= {ready_sync[0], ready_pin_in};
    refresh_sync <= {refresh_sync[0], refresh_n_pin_in};
    check_sync <= {check_sync[0], chan_check_n_in};
    cs16_sync <= {cs16_sync[0], mem_cs16_n_in};
    irq_meta <= irq_muxed_in;
    irq_sync <= irq_meta;
    dreq_meta <= dma_req_muxed_in;
    dreq_sync <= dreq_meta;
    addr_meta <= addr_pins_in;
    addr_sync <= addr_meta;
    cmd_meta <= cmd_pins_in;
    cmd_sync <= cmd_meta;
  end

  // ********************************************
  // Decode
  // ********************************************
  function automatic logic below_meg(input logic [23:0] a);
    below_meg = (a < `EBH_ONE_MEG);
  endfunction : below_meg

  ebh_state_t state, next_state;
  ebh_req_t cur;
  logic [3:0] count;
  logic [1:0] hold_count;
  logic [1:0] phase;
  logic phase_tick;
  logic bus_clk, bus_clk2;

  wire master_own = ~master_sync[1];
  wire io_cyc = cur.is_io & ~cur.is_refresh;
  wire mem_cyc = ~cur.is_io | cur.is_refresh;
  wire in_cmd = (state == EBH_CMD);
  wire is_clock_port = io_cyc & (cur.addr[15:1] == 15'(`EBH_CLOCK_ADDR_PORT >> 1));
  wire ext_ready = ready_sync[1];
  wire cmd_end = (count == 4'(CYCLE_LEN - 1)) & ext_ready;
  // Master access to internal ports: io command to clock chip ports
  wire master_io = master_own & (~cmd_sync.ior_n | ~cmd_sync.iow_n)
                   & (addr_sync[15:1] == 15'(`EBH_CLOCK_ADDR_PORT >> 1));

  // ********************************************
  // Cycle sequencer
  // ********************************************
  always_comb begin
    next_state = state;
    unique case (state)
      EBH_IDLE: if (req_in.valid & ~master_own) next_state = EBH_ADDR;
      EBH_ADDR: next_state = EBH_CMD;
      EBH_CMD: if (cmd_end) next_state = EBH_DONE;
      EBH_DONE: next_state = EBH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= EBH_IDLE;
      cur <= '0;
      count <= 4'h0;
    end else begin
      state <= next_state;
      if (state == EBH_IDLE && req_in.valid) begin
        cur <= req_in;
      end
      count <= (in_cmd && !cmd_end) ? ((count == 4'(CYCLE_LEN - 1)) ? count : count + 4'h1) : 4'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hold_count <= 2'h0;
    end else if (state == EBH_IDLE && req_in.valid && req_in.is_refresh && !master_own) begin
      hold_count <= 2'(HOLD_LEN);
    end else if (hold_count != 2'h0) begin
      hold_count <= hold_count - 2'h1;
    end
  end

  // ********************************************
  // Pin drivers
  // ********************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      upper_addr_out <= 7'h00;
      upper_addr_oe_out <= 1'b0;
      low_addr_out <= 20'h0_0000;
      cmd_oe_out <= 1'b0;
      cmd_out <= '1;
      ale_out <= 1'b0;
      aen_out <= 1'b0;
      refresh_n_out <= 1'b1;
      refresh_oe_out <= 1'b0;
      busy_out <= 1'b0;
      host_bus_hold_out <= 1'b0;
      tc_out <= 1'b0;
    end else begin
      upper_addr_oe_out <= ~master_own;
      upper_addr_out <= cur.addr[23:17];
      low_addr_out <= cur.addr[19:0];
      cmd_oe_out <= ~master_own;
      ale_out <= (state == EBH_ADDR) | (in_cmd & (cur.is_refresh | cur.is_dma)) | master_own;
      aen_out <= (state != EBH_IDLE) & cur.is_dma;
      refresh_n_out <= ~((state != EBH_IDLE) & cur.is_refresh);
      refresh_oe_out <= ~master_own;
      cmd_out.memr_n <= ~(in_cmd & mem_cyc & (~cur.is_write | cur.is_refresh));
      cmd_out.memw_n <= ~(in_cmd & mem_cyc & cur.is_write & ~cur.is_refresh);
      cmd_out.smemr_n <= ~(in_cmd & mem_cyc & ~cur.is_write
                           & (below_meg(cur.addr) | cur.is_refresh));
      cmd_out.smemw_n <= ~(in_cmd & mem_cyc & cur.is_write & ~cur.is_refresh
                           & below_meg(cur.addr));
      cmd_out.ior_n <= ~(in_cmd & io_cyc & ~cur.is_write);
      cmd_out.iow_n <= ~(in_cmd & io_cyc & cur.is_write);
      cmd_out.bhe_n <= ~((state != EBH_IDLE) & cur.high_byte & ~cur.is_refresh);
      busy_out <= (next_state != EBH_IDLE);
      host_bus_hold_out <= (hold_count != 2'h0);
      tc_out <= in_cmd & cur.is_dma & dma_last_in;
    end
  end

  // ********************************************
  // External master handling
  // ********************************************
  logic [3:0] master_count;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      master_count <= 4'h0;
      ready_out <= 1'b1;
      ready_oe_out <= 1'b0;
      master_active_out <= 1'b0;
      master_refresh_req_out <= 1'b0;
      master_internal_io_out <= 1'b0;
      master_addr_out <= 24'h00_0000;
      mem_cs16_out <= 1'b0;
      io_cs16_n_out <= 1'b1;
      io_cs16_oe_out <= 1'b0;
      nmi_out <= 1'b0;
    end else begin
      master_active_out <= master_own;
      master_addr_out <= addr_sync;
      master_refresh_req_out <= master_own & ~refresh_sync[1];
      // extended 8-bit internal cycle, IO chip select never driven
      master_internal_io_out <= master_io;
      io_cs16_oe_out <= 1'b0;
      master_count <= master_io ? ((master_count == 4'(CYCLE_LEN)) ? master_count
                                   : master_count + 4'h1) : 4'h0;
      // drive ready for master target; master waits on it
      ready_oe_out <= master_io;
      ready_out <= ~master_io | (master_count == 4'(CYCLE_LEN));
      // chip select ignored in IO and refresh
      mem_cs16_out <= ~cs16_sync[1] & ~cur.is_io & ~cur.is_refresh & (state != EBH_IDLE);
      nmi_out <= ~check_sync[1] & nmi_enable_in;
    end
  end

  // ********************************************
  // Decode strobes
  // ********************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      clock_chip_addr_strobe_n_out <= 1'b1;
      clock_chip_write_strobe_n_out <= 1'b1;
      clock_chip_data_strobe_n_out <= 1'b1;
      boot_rom_clock_chip_sel_n_out <= 1'b1;
      aux_latch_select_n_out <= 1'b1;
    end else begin
      clock_chip_addr_strobe_n_out <= ~(in_cmd & io_cyc & cur.is_write
                                        & cur.addr[15:0] == `EBH_CLOCK_ADDR_PORT);
      clock_chip_write_strobe_n_out <= ~(in_cmd & io_cyc & cur.is_write
                                         & cur.addr[15:0] == `EBH_CLOCK_DATA_PORT);
      clock_chip_data_strobe_n_out <= ~(in_cmd & io_cyc & ~cur.is_write
                                        & cur.addr[15:0] == `EBH_CLOCK_DATA_PORT);
      boot_rom_clock_chip_sel_n_out <= ~((state != EBH_IDLE)
                                         & ((mem_cyc & cur.is_rom & ~cur.is_refresh)
                                            | is_clock_port));
      aux_latch_select_n_out <= ~(in_cmd & io_cyc & cur.is_write & aux_latch_req_in);
    end
  end

  // ********************************************
  // Multiplexed interrupts and DMA
  // ********************************************
  // bus clock and companion
  ebh_mux_phase #(.DIV(`EBH_CLK_DIV)) u_phase (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .bus_clock_out(bus_clk),
    .bus_clock_double_out(bus_clk2),
    .phase_tick_out(phase_tick)
  );

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase <= 2'h0;
      irq_request_out <= 16'h0000;
      dma_request_out <= 8'h00;
      dma_ack_encoded_out <= 3'h0;
      expansion_bus_clock_out <= 1'b0;
      expansion_bus_clock_double_out <= 1'b0;
    end else begin
      expansion_bus_clock_out <= bus_clk;
      expansion_bus_clock_double_out <= bus_clk2;
      dma_ack_encoded_out <= (state != EBH_IDLE && cur.is_dma) ? dma_channel_in : 3'h0;
      if (phase_tick) begin
        phase <= phase + 2'h1;
        // demultiplex per phase; line 8 inverted
        irq_request_out[{phase, 2'h0} +: 4] <= (phase == 2'h2) ?
          {irq_sync[3:1], ~irq_sync[0]} : irq_sync;
        dma_request_out[{phase, 1'b0} +: 2] <= dreq_sync;
      end
    end
  end
  // Line 8 arrives active low so the clock chip needs no inverter

  // ********************************************
  // Checks
  // ********************************************
  a_upper_addr_dir: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    master_sync[1] == 1'b0 |=> !upper_addr_oe_out) else $error("upper address driven");
  a_cmd_dir: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    master_own |=> !cmd_oe_out) else $error("commands driven under master");
  a_ready_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ready_oe_out |-> $past(master_io)) else $error("ready driven without target");
  a_ale_refresh: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (in_cmd && cur.is_refresh) |=> ale_out) else $error("ale low in refresh");
  a_memr_refresh: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (in_cmd && cur.is_refresh) |=> !cmd_out.memr_n) else $error("memr idle in refresh");
  a_smemw_meg: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !cmd_out.smemw_n |-> $past(below_meg(cur.addr))) else $error("smemw above 1M");
  a_io_cs16: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !io_cs16_oe_out) else $error("io chip select driven");
  sequence s_refresh_start;
    state == EBH_IDLE && req_in.valid && req_in.is_refresh && !master_own;
  endsequence
  a_refresh_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_refresh_start |=> ##1 host_bus_hold_out ##1 host_bus_hold_out ##1 !host_bus_hold_out)
    else $error("host hold not two clocks");
  a_aen_dma: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    aen_out |-> $past(cur.is_dma)) else $error("aen outside dma");
  a_nmi_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    nmi_out |-> $past(nmi_enable_in)) else $error("nmi while disabled");
  a_tc_dma: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tc_out |-> $past(cur.is_dma && dma_last_in)) else $error("tc outside last dma");
endmodule : ebh_isa_host

// file: tb/ebh_isa_cards.sv
`timescale 1ns/10ps
// ****************************************
// Add-on card and bus master side of the bus
// ****************************************
module ebh_isa_cards (
  input wire logic ref_clk_in,
  input wire ebh_pkg::ebh_cmd_t cmd_drv_in,
  input wire logic cmd_oe_in,
  input wire logic [23:0] addr_drv_in,
  input wire logic addr_oe_in,
  input wire logic ready_drv_in,
  input wire logic ready_oe_in,
  input wire logic refresh_drv_in,
  input wire logic refresh_oe_in,
  input wire logic [3:0] wait_len_in,
  input wire logic master_req_in,
  input wire logic [23:0] master_addr_in,
  input wire logic master_ref_in,
  input wire ebh_pkg::ebh_cmd_t master_cmd_in,
  output logic master_n_out,
  output logic [23:0] addr_pins_out,
  output ebh_pkg::ebh_cmd_t cmd_pins_out,
  output logic ready_pin_out,
  output logic refresh_n_pin_out
);
  import ebh_pkg::*;
  logic [3:0] wait_cnt;
  logic [23:0] last_addr;
  logic strobe_low;
  // Any command strobe except bhe_n active from the host side
  assign strobe_low = cmd_oe_in && (cmd_drv_in[6:1] != 6'h3f);
  assign master_n_out = !master_req_in;
  // Undriven address lines have no pull, so show the inverse of the last value
  assign addr_pins_out = addr_oe_in ? addr_drv_in : (master_req_in ? master_addr_in : ~last_addr);
  // Granted master drives commands; otherwise the lines are pulled up
  assign cmd_pins_out = cmd_oe_in ? cmd_drv_in : (master_req_in ? master_cmd_in : 7'h7f);
  assign refresh_n_pin_out = refresh_oe_in ? refresh_drv_in : !master_ref_in;
  assign ready_pin_out = ready_oe_in ? ready_drv_in : !(strobe_low && wait_cnt != 4'h0);
  // Slow card: reload the wait count between commands
  always_ff @(posedge ref_clk_in) begin
    last_addr <= addr_pins_out;
    if (!strobe_low) wait_cnt <= wait_len_in;
    else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
  end
endmodule : ebh_isa_cards

// file: tb/test_isa_bus_host_interface.sv
`timescale 1ns/10ps
module test_isa_bus_host_interface;
  import ebh_pkg::*;
  logic ref_clk_in, reset_in, dma_last_in, nmi_enable_in, aux_latch_req_in, ready_pin_in;
  logic master_n_in, refresh_n_pin_in, mem_cs16_n_in, chan_check_n_in;
  logic [2:0] dma_channel_in, dma_ack_encoded_out;
  ebh_req_t req_in;
  ebh_cmd_t cmd_pins_in, cmd_out, master_cmd;
  logic [23:0] addr_pins_in, master_addr_out, master_addr;
  logic [3:0] irq_muxed_in, wait_len;
  logic [1:0] dma_req_muxed_in;
  logic busy_out, host_bus_hold_out, master_active_out, master_refresh_req_out;
  logic master_internal_io_out, mem_cs16_out, upper_addr_oe_out, cmd_oe_out, ready_out;
  logic ready_oe_out, refresh_n_out, refresh_oe_out, ale_out, aen_out, io_cs16_n_out;
  logic io_cs16_oe_out, nmi_out, tc_out, aux_latch_select_n_out, clock_chip_addr_strobe_n_out;
  logic clock_chip_write_strobe_n_out, clock_chip_data_strobe_n_out;
  logic boot_rom_clock_chip_sel_n_out, expansion_bus_clock_out, expansion_bus_clock_double_out;
  logic [23:17] upper_addr_out;
  logic [19:0] low_addr_out;
  logic [15:0] irq_request_out;
  logic [7:0] dma_request_out;
  logic master_req, master_ref, collect, prev_c, prev_d, seen_cs;
  logic [2:0] seen_ack;
  logic [6:0] seen_cmd;
  logic [4:0] seen_side;
  logic [5:0] seen_misc;
  logic [29:0] corner [0:10];
  int err_total, comparisons, hold_cnt, n_c, n_d;

  ebh_isa_host #(.CYCLE_LEN(6), .HOLD_LEN(2)) DUT (.ref_clk_in, .reset_in, .req_in, .dma_last_in,
    .dma_channel_in, .nmi_enable_in, .aux_latch_req_in, .busy_out, .host_bus_hold_out,
    .master_active_out, .master_refresh_req_out, .master_internal_io_out, .master_addr_out,
    .mem_cs16_out, .master_n_in, .addr_pins_in, .cmd_pins_in, .ready_pin_in, .refresh_n_pin_in,
    .mem_cs16_n_in, .chan_check_n_in, .irq_muxed_in, .dma_req_muxed_in, .upper_addr_out,
    .upper_addr_oe_out, .low_addr_out, .cmd_out, .cmd_oe_out, .ready_out, .ready_oe_out,
    .refresh_n_out, .refresh_oe_out, .ale_out, .aen_out, .io_cs16_n_out, .io_cs16_oe_out,
    .nmi_out, .tc_out, .dma_ack_encoded_out, .aux_latch_select_n_out,
    .clock_chip_addr_strobe_n_out, .clock_chip_write_strobe_n_out, .clock_chip_data_strobe_n_out,
    .boot_rom_clock_chip_sel_n_out, .irq_request_out, .dma_request_out, .expansion_bus_clock_out,
    .expansion_bus_clock_double_out);

  ebh_isa_cards cards (.ref_clk_in, .cmd_drv_in(cmd_out), .cmd_oe_in(cmd_oe_out),
    .addr_drv_in({upper_addr_out, low_addr_out[16:0]}), .addr_oe_in(upper_addr_oe_out),
    .ready_drv_in(ready_out), .ready_oe_in(ready_oe_out), .refresh_drv_in(refresh_n_out),
    .refresh_oe_in(refresh_oe_out), .wait_len_in(wait_len), .master_req_in(master_req),
    .master_addr_in(master_addr), .master_ref_in(master_ref), .master_cmd_in(master_cmd),
    .master_n_out(master_n_in),
    .addr_pins_out(addr_pins_in), .cmd_pins_out(cmd_pins_in), .ready_pin_out(ready_pin_in),
    .refresh_n_pin_out(refresh_n_pin_in));

  // Clock at 250 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Gather which strobes fired during a cycle; bus clock edges always counted
  always @(posedge ref_clk_in) begin
    prev_c <= expansion_bus_clock_out;
    prev_d <= expansion_bus_clock_double_out;
    n_c <= n_c + int'(prev_c !== expansion_bus_clock_out);
    n_d <= n_d + int'(prev_d !== expansion_bus_clock_double_out);
    if (collect) begin
      seen_cmd <= seen_cmd | (~cmd_out & {7{cmd_oe_out}});
      seen_side <= seen_side | ~{clock_chip_addr_strobe_n_out, clock_chip_write_strobe_n_out,
        clock_chip_data_strobe_n_out, boot_rom_clock_chip_sel_n_out, aux_latch_select_n_out};
      seen_misc <= seen_misc | {ale_out, aen_out, tc_out, ready_oe_out, upper_addr_oe_out,
        refresh_oe_out & ~refresh_n_out};
      hold_cnt <= hold_cnt + int'(host_bus_hold_out);
      seen_cs <= seen_cs | mem_cs16_out;
      seen_ack <= seen_ack | dma_ack_encoded_out;
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // Flags: io, write, refresh, dma, rom, high byte
  function automatic ebh_req_t mk(input logic [5:0] f, input logic [23:0] a);
    mk = {1'b1, f, a};
  endfunction : mk

  // Active command strobes, memr_n down to bhe_n
  function automatic logic [6:0] exp_cmd(input ebh_req_t r);
    logic low;
    low = r.addr < 24'h10_0000;
    if (r.is_refresh) return 7'h50;
    if (r.is_io) return r.is_write ? 7'h02 : 7'h04;
    if (r.is_write) return {1'b0, 1'b1, 1'b0, low, 2'b00, r.high_byte};
    return {1'b1, 1'b0, low, 3'b000, r.high_byte};
  endfunction : exp_cmd

  // Clock chip strobes, shared select and aux latch strobe
  function automatic logic [4:0] exp_side(input ebh_req_t r, input logic aux);
    logic p70, p71;
    p70 = r.is_io && r.addr[15:0] == 16'h0070;
    p71 = r.is_io && r.addr[15:0] == 16'h0071;
    return {p70 && r.is_write, p71 && r.is_write, p71 && !r.is_write,
      p70 || p71 || (r.is_rom && !r.is_io), aux && r.is_io && r.is_write};
  endfunction : exp_side

  // One host cycle; request held until busy shows, bounded waits
  task automatic run(input ebh_req_t r, input logic [3:0] wl);
    int n;
    @(negedge ref_clk_in);
    req_in = r;
    wait_len = wl;
    seen_cmd = '0;
    seen_side = '0;
    seen_misc = '0;
    hold_cnt = 0;
    seen_cs = 1'b0;
    seen_ack = 3'h0;
    collect = 1'b1;
    n = 0;
    while (busy_out !== 1'b1 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    req_in.valid = 1'b0;
    while (busy_out !== 1'b0 && n < 200) begin
      @(negedge ref_clk_in);
      n++;
    end
    collect = 1'b0;
    chk(n < 200, 1'b1, "cycle completes");
    chk({upper_addr_out, low_addr_out}, {r.addr[23:17], r.addr[19:0]}, "address pins");
    chk(seen_cs, !mem_cs16_n_in && !r.is_io && !r.is_refresh, "memory chip select");
    chk(seen_ack, r.is_dma ? dma_channel_in : 3'h0, "dma acknowledge");
    if (!r.is_dma) chk(seen_cmd, exp_cmd(r), "command strobes");
    chk(seen_side, exp_side(r, aux_latch_req_in), "decode strobes");
    chk(seen_misc[5], 1'b1, "address latch enable");
    if (!r.is_refresh) chk(seen_misc[4], r.is_dma, "address enable");
    chk(seen_misc[3], r.is_dma && dma_last_in, "terminal count");
    chk(seen_misc[2], 1'b0, "ready not driven");
    if (!r.is_refresh && !r.is_dma) chk(seen_misc[1], 1'b1, "upper address driven");
    chk(seen_misc[0], r.is_refresh, "refresh output");
    chk(hold_cnt, r.is_refresh ? 2 : 0, "host bus hold");
  endtask : run

  initial begin
    #100000;
    err_total++;
    close_out();
  end

  initial begin
    {reset_in, dma_last_in, nmi_enable_in, aux_latch_req_in, master_req, master_ref} = 6'h20;
    {collect, prev_c, prev_d, n_c, n_d, hold_cnt} = '0;
    {mem_cs16_n_in, chan_check_n_in, dma_channel_in, wait_len} = {2'b11, 7'h00};
    {irq_muxed_in, dma_req_muxed_in, master_addr, req_in} = '0;
    master_cmd = 7'h7f;
    corner = '{{6'h01, 24'h0F_FFFF}, {6'h00, 24'h10_0000}, {6'h10, 24'h0F_FFFF},
      {6'h11, 24'h10_0000}, {6'h30, 24'h00_0070}, {6'h30, 24'h00_0071}, {6'h20, 24'h00_0071},
      {6'h20, 24'h00_0070}, {6'h02, 24'h0F_0000}, {6'h08, 24'h00_0000}, {6'h04, 24'h01_2345}};
    void'($urandom(32'h592a));
    repeat (6) @(negedge ref_clk_in);
    chk({cmd_oe_out, upper_addr_oe_out, ale_out}, 3'b000, "quiet in reset");
    reset_in = 1'b0;
    @(negedge ref_clk_in);
    chk({cmd_oe_out, upper_addr_oe_out, ale_out}, 3'b110, "idle after reset");
    chk({io_cs16_oe_out, refresh_oe_out, cmd_out}, 9'h0ff, "released pins");
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      aux_latch_req_in = i[0];
      dma_last_in = i[1];
      mem_cs16_n_in = !i[0];
      dma_channel_in = 3'(i);
      run(mk(corner[i][29:24], corner[i][23:0]), 4'(i % 4));
    end
    $display("test corners done");
    for (int i = 0; i < 24; i++) begin
      logic [1:0] k;
      logic [23:0] a;
      k = 2'($urandom);
      a = 24'($urandom);
      if (k[1]) a = (i % 3 == 0) ? 24'h00_0070 : ((i % 3 == 1) ? 24'h00_0071 : a);
      aux_latch_req_in = 1'($urandom);
      dma_channel_in = 3'($urandom);
      mem_cs16_n_in = 1'($urandom);
      run(mk({k, 3'b000, !k[1] & a[0]}, a), 4'($urandom % 4));
    end
    $display("test random done");
    @(negedge ref_clk_in);
    master_req = 1'b1;
    master_addr = 24'($urandom);
    repeat (3) @(negedge ref_clk_in);
    req_in = mk(6'h00, 24'h00_1000);
    repeat (8) @(negedge ref_clk_in);
    chk(busy_out, 1'b0, "request refused under master");
    chk({upper_addr_oe_out, cmd_oe_out}, 2'b00, "pins released to master");
    chk({master_active_out, ale_out}, 2'b11, "master owns bus");
    chk(master_addr_out, master_addr, "master address seen");
    chk(master_refresh_req_out, 1'b0, "no master refresh yet");
    master_ref = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk(master_refresh_req_out, 1'b1, "master refresh request");
    master_addr = 24'h00_0070;
    master_cmd = 7'h7d;
    repeat (4) @(negedge ref_clk_in);
    chk({ready_oe_out, ready_out, master_internal_io_out}, 3'b101, "ready held low");
    chk(io_cs16_oe_out, 1'b0, "io chip select released");
    repeat (8) @(negedge ref_clk_in);
    chk({ready_oe_out, ready_out}, 2'b11, "extended cycle ends");
    master_cmd = 7'h7f;
    {master_ref, master_req, req_in.valid} = 3'b000;
    repeat (6) @(negedge ref_clk_in);
    $display("test master done");
    chan_check_n_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk(nmi_out, 1'b0, "check masked");
    nmi_enable_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk(nmi_out, 1'b1, "check enabled");
    $display("test channel check done");
    irq_muxed_in = 4'hf;
    dma_req_muxed_in = 2'h3;
    repeat (40) @(negedge ref_clk_in);
    chk(irq_request_out, 16'hfeff, "all requests high");
    chk(dma_request_out, 8'hff, "dma requests high");
    {irq_muxed_in, dma_req_muxed_in} = 6'h00;
    repeat (40) @(negedge ref_clk_in);
    chk(irq_request_out, 16'h0100, "all requests low");
    chk(dma_request_out, 8'h00, "dma requests low");
    {n_c, n_d} = '0;
    repeat (64) @(negedge ref_clk_in);
    chk(n_c > 0 && n_d == 2 * n_c, 1'b1, "double rate clock");
    $display("test mux and clocks done");
    close_out();
  end
endmodule : test_isa_bus_host_interface
